//--- verilog/charger_setup_regs.vh
`ifndef CHARGER_SETUP_REGS_VH
`define CHARGER_SETUP_REGS_VH
// ****************************************
// register offsets
// ****************************************
`define OFS_CABLE_COMP 8'h01
`define OFS_CURRENT_LIMIT_SETUP 8'h02
`define OFS_PORT_MODE_SETUP 8'h03
`define OFS_CONFIG_DONE_CONTROL 8'h04
`define OFS_SAMPLE_TRIGGER 8'h05
// ****************************************
// field positions
// ****************************************
`define GAIN_MSB 4
`define GAIN_LSB 0
`define THRESH_MSB 2
`define THRESH_LSB 0
`define RETRY_SEL_BIT 4
`define RETRY_PERIOD_MSB 7
`define RETRY_PERIOD_LSB 6
`define CHG_DET_MSB 5
`define CHG_DET_LSB 4
`define TYPEC_DIS_BIT 3
`define VCONN_EN_BIT 2
`define SRC_CUR_MSB 1
`define SRC_CUR_LSB 0
`define CONFIGURED_BIT 0
`define SAMPLE_REQ_BIT 0
// ****************************************
// reset values and decodes
// ****************************************
`define RST_CABLE_COMP 8'h00
`define RST_CURRENT_LIMIT_SETUP 8'h07
`define RST_PORT_MODE_SETUP 8'h05
`define RST_CONFIG_DONE_CONTROL 8'h00
`define RST_SAMPLE_TRIGGER 8'h00
`define RST_READ_DATA 8'h00
`define MASK_CABLE_COMP 8'h1F
`define MASK_CURRENT_LIMIT_SETUP 8'h17
`define MASK_CONFIG_DONE_CONTROL 8'h01
`define CHG_DET_SDP 2'h0
`define CHG_DET_CDP 2'h1
`define COMP_STEP_MOHM 10'h012
`endif

//--- verilog/sample_handshake.v
`timescale 1ns/1ps
`default_nettype none
// holds one sample request until the converter reports done
module sample_handshake (
  input wire i_clk,
  input wire i_nrst,
  input wire i_set,
  input wire i_done,
  output wire o_busy,
  output wire o_start
);
  reg busy_q;
  reg started_q;
  // set wins over done so a fresh request is never lost
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      busy_q <= 1'b0;
      started_q <= 1'b0;
    end else if (i_set) begin
      busy_q <= 1'b1;
      started_q <= 1'b0;
    end else if (busy_q && i_done) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      started_q <= 1'b1;
    end
  end
  assign o_busy = busy_q;
  assign o_start = busy_q && !started_q;
endmodule
`default_nettype wire

//--- verilog/usb_charger_setup_registers.v
`timescale 1ns/1ps
`default_nettype none
`include "charger_setup_regs.vh"
module usb_charger_setup_registers (
  input wire i_clk,
  input wire i_nrst,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  output wire o_addr_valid,
  input wire i_sample_done,
  output wire o_sample_start,
  output reg [4:0] o_comp_gain_code,
  output reg [9:0] o_comp_resistance_mohm,
  output reg [2:0] o_usb_current_threshold_code,
  output reg o_bus_limit_undervoltage_fault_en,
  output reg [1:0] o_fault_retry_period,
  output reg o_chg_det_sdp,
  output reg o_chg_det_cdp,
  output reg o_chg_det_reserved,
  output reg o_typec_detect_disable,
  output reg o_cable_power_passthru_enable,
  output reg [1:0] o_advertised_source_current,
  output reg o_converter_enable
);
  // ****************************************
  // reset images of the decoded outputs
  // ****************************************
  // derived from the register reset words so the decoded outputs and
  // the readback can never disagree straight after reset
  localparam [7:0] COMP_RST = `RST_CABLE_COMP;
  localparam [7:0] LIMIT_RST = `RST_CURRENT_LIMIT_SETUP;
  localparam [7:0] PORT_RST = `RST_PORT_MODE_SETUP;
  localparam [7:0] DONE_RST = `RST_CONFIG_DONE_CONTROL;
  localparam [1:0] PORT_RST_DET = PORT_RST[`CHG_DET_MSB:`CHG_DET_LSB];
  localparam [9:0] COMP_RST_MOHM = {5'h00, COMP_RST[`GAIN_MSB:`GAIN_LSB]} * `COMP_STEP_MOHM;
  // ****************************************
  // storage
  // ****************************************
  reg [7:0] comp_q;
  reg [7:0] limit_q;
  reg [7:0] port_q;
  reg [7:0] done_q;
  wire sample_busy;
  wire wr_comp;
  wire wr_limit;
  wire wr_port;
  wire wr_done;
  wire wr_sample;
  wire [1:0] det_code;
  // one strobe per register; a write to a hole matches none of them
  assign wr_comp = i_wr_en && (i_addr == `OFS_CABLE_COMP);
  assign wr_limit = i_wr_en && (i_addr == `OFS_CURRENT_LIMIT_SETUP);
  assign wr_port = i_wr_en && (i_addr == `OFS_PORT_MODE_SETUP);
  assign wr_done = i_wr_en && (i_addr == `OFS_CONFIG_DONE_CONTROL);
  // writing zero to the trigger is a no-op, only a one starts a sample
  assign wr_sample = i_wr_en && (i_addr == `OFS_SAMPLE_TRIGGER) && i_wdata[`SAMPLE_REQ_BIT];
  assign o_addr_valid = (i_addr >= `OFS_CABLE_COMP) && (i_addr <= `OFS_SAMPLE_TRIGGER);
  assign det_code = port_q[`CHG_DET_MSB:`CHG_DET_LSB];
  // gain register; upper bits are not stored so they read back zero
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      comp_q <= `RST_CABLE_COMP;
    end else if (wr_comp) begin
      comp_q <= i_wdata & `MASK_CABLE_COMP;
    end
  end
  // current-limit setup; bits 7:5 and 3 are holes and stay zero
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      limit_q <= `RST_CURRENT_LIMIT_SETUP;
    end else if (wr_limit) begin
      limit_q <= i_wdata & `MASK_CURRENT_LIMIT_SETUP;
    end
  end
  // port setup; every bit is a field, so no mask
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      port_q <= `RST_PORT_MODE_SETUP;
    end else if (wr_port) begin
      port_q <= i_wdata;
    end
  end
  // configured flag; software may clear it again to stop the converter
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      done_q <= `RST_CONFIG_DONE_CONTROL;
    end else if (wr_done) begin
      done_q <= i_wdata & `MASK_CONFIG_DONE_CONTROL;
    end
  end
  // ****************************************
  // sample request
  // ****************************************
  // request bit lives in the handshake so hardware can clear it
  sample_handshake u_sample (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_set(wr_sample),
    .i_done(i_sample_done),
    .o_busy(sample_busy),
    .o_start(o_sample_start)
  );
  // ****************************************
  // read path
  // ****************************************
  // registered so the data holds until the next read; holes read zero
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rdata <= `RST_READ_DATA;
    end else if (i_rd_en) begin
      case (i_addr)
        `OFS_CABLE_COMP: o_rdata <= comp_q;
        `OFS_CURRENT_LIMIT_SETUP: o_rdata <= limit_q;
        `OFS_PORT_MODE_SETUP: o_rdata <= port_q;
        `OFS_CONFIG_DONE_CONTROL: o_rdata <= done_q;
        `OFS_SAMPLE_TRIGGER: o_rdata <= {7'h00, sample_busy};
        default: o_rdata <= 8'h00;
      endcase
    end
  end
  // ****************************************
  // decoded controls, registered for clean outputs
  // ****************************************
  // every control follows its register one edge later, so a write
  // shows on the pins two edges after the strobe; the extra flop
  // keeps the decode glitch-free toward the analog side
  // gain code as stored
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_comp_gain_code <= COMP_RST[`GAIN_MSB:`GAIN_LSB];
    end else begin
      o_comp_gain_code <= comp_q[`GAIN_MSB:`GAIN_LSB];
    end
  end
  // emulated cable resistance; product fits 10 bits: 31 * 18 = 558
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_comp_resistance_mohm <= COMP_RST_MOHM;
    end else begin
      o_comp_resistance_mohm <= {5'h00, comp_q[`GAIN_MSB:`GAIN_LSB]} * `COMP_STEP_MOHM;
    end
  end
  // usb dc current threshold code
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_usb_current_threshold_code <= LIMIT_RST[`THRESH_MSB:`THRESH_LSB];
    end else begin
      o_usb_current_threshold_code <= limit_q[`THRESH_MSB:`THRESH_LSB];
    end
  end
  // undervoltage fault is live while the retry select bit is clear
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_bus_limit_undervoltage_fault_en <= !LIMIT_RST[`RETRY_SEL_BIT];
    end else begin
      o_bus_limit_undervoltage_fault_en <= !limit_q[`RETRY_SEL_BIT];
    end
  end
  // retry timer length passes straight through
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_fault_retry_period <= PORT_RST[`RETRY_PERIOD_MSB:`RETRY_PERIOD_LSB];
    end else begin
      o_fault_retry_period <= port_q[`RETRY_PERIOD_MSB:`RETRY_PERIOD_LSB];
    end
  end
  // charge detect one-hot; both reserved codes raise the same flag
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_chg_det_sdp <= (PORT_RST_DET == `CHG_DET_SDP);
      o_chg_det_cdp <= (PORT_RST_DET == `CHG_DET_CDP);
      o_chg_det_reserved <= PORT_RST_DET[1];
    end else begin
      o_chg_det_sdp <= (det_code == `CHG_DET_SDP);
      o_chg_det_cdp <= (det_code == `CHG_DET_CDP);
      o_chg_det_reserved <= det_code[1];
    end
  end
  // type-c detection disable
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_typec_detect_disable <= PORT_RST[`TYPEC_DIS_BIT];
    end else begin
      o_typec_detect_disable <= port_q[`TYPEC_DIS_BIT];
    end
  end
  // advertised source current code
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_advertised_source_current <= PORT_RST[`SRC_CUR_MSB:`SRC_CUR_LSB];
    end else begin
      o_advertised_source_current <= port_q[`SRC_CUR_MSB:`SRC_CUR_LSB];
    end
  end
  // gated by the configured flag too: no cable power before setup,
  // at the cost of the enable bit alone not showing on the pin
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_cable_power_passthru_enable <= PORT_RST[`VCONN_EN_BIT] && DONE_RST[`CONFIGURED_BIT];
    end else begin
      o_cable_power_passthru_enable <= port_q[`VCONN_EN_BIT] && done_q[`CONFIGURED_BIT];
    end
  end
  // converter stays off until software declares setup complete
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_converter_enable <= DONE_RST[`CONFIGURED_BIT];
    end else begin
      o_converter_enable <= done_q[`CONFIGURED_BIT];
    end
  end
endmodule
`default_nettype wire

//--- verification/sample_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// converter stand-in
// ****************
module sample_conv_model #(parameter int DLY = 4) (
  input wire logic i_clk,
  input wire logic i_start,
  output wire logic o_done
);
  int cnt = 0;
  logic done_q = 1'b0;
  // answers slowly so the request bit is seen pending
  always @(posedge i_clk) begin
    cnt <= i_start ? DLY : (cnt > 0 ? cnt - 1 : 0);
    done_q <= (cnt == 1);
  end
  assign o_done = done_q;
endmodule
`default_nettype wire

//--- verification/setup_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// port relations
// ****************
module setup_checker (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_addr_valid,
  input wire logic o_sample_start,
  input wire logic [4:0] o_comp_gain_code,
  input wire logic [9:0] o_comp_resistance_mohm,
  input wire logic o_bus_limit_undervoltage_fault_en,
  input wire logic o_chg_det_sdp,
  input wire logic o_chg_det_cdp,
  input wire logic o_cable_power_passthru_enable,
  input wire logic o_converter_enable
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // write checks on 02-04 look three edges after the write, the start check one edge after; gain scale and vconn gate are checked every edge
  gain_scale_a: assert property (o_comp_resistance_mohm == 10'(o_comp_gain_code) * 10'h012)
    else $error("gain scale");
  fault_en_a: assert property (i_wr_en && i_addr == 8'h02 |-> ##3
    o_bus_limit_undervoltage_fault_en == !$past(i_wdata[4], 3)) else $error("fault enable");
  chg_det_decode_a: assert property (i_wr_en && i_addr == 8'h03 |-> ##3
    {o_chg_det_sdp, o_chg_det_cdp} == {$past(i_wdata[5:4], 3) == 2'h0, $past(i_wdata[5:4], 3) == 2'h1})
    else $error("charge detect");
  vconn_follow_a: assert property (i_wr_en && i_addr == 8'h03 |-> ##3
    o_cable_power_passthru_enable == ($past(i_wdata[2], 3) && o_converter_enable)) else $error("vconn follow");
  vconn_gate_a: assert property (o_cable_power_passthru_enable |-> o_converter_enable)
    else $error("vconn");
  conv_hold_a: assert property (i_wr_en && i_addr == 8'h04 |-> ##3
    o_converter_enable == $past(i_wdata[0], 3)) else $error("converter");
  start_pulse_a: assert property (i_wr_en && i_addr == 8'h05 && i_wdata[0] |=> o_sample_start ##1 !o_sample_start)
    else $error("start");
  unmapped_read_a: assert property (i_rd_en && !o_addr_valid |=> o_rdata == 8'h00) else $error("unmapped");
endmodule
bind usb_charger_setup_registers setup_checker chk_u (.*);
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_clk = 0, i_nrst = 0, i_wr_en = 0, i_rd_en = 0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
  int bad_count = 0, cmp_count = 0;
  wire [7:0] o_rdata;
  wire [9:0] o_comp_resistance_mohm;
  wire [4:0] o_comp_gain_code;
  wire [2:0] o_usb_current_threshold_code;
  wire [1:0] o_fault_retry_period, o_advertised_source_current;
  wire o_addr_valid, o_sample_start, i_sample_done, o_bus_limit_undervoltage_fault_en, o_chg_det_sdp;
  wire o_chg_det_cdp, o_chg_det_reserved, o_typec_detect_disable, o_cable_power_passthru_enable;
  wire o_converter_enable;
  usb_charger_setup_registers dut_u (.*);
  sample_conv_model conv_u (.i_clk(i_clk), .i_start(o_sample_start), .o_done(i_sample_done));
  initial forever #2.5 i_clk = ~i_clk;
  task chk(input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one strobe, then let the decoded outputs settle
  task op(input logic w, input logic [7:0] a, d);
    @(posedge i_clk);
    #1 i_wr_en = w;
    i_rd_en = !w;
    i_addr = a;
    i_wdata = d;
    @(posedge i_clk);
    #1 i_wr_en = 0;
    i_rd_en = 0;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  task rd(input logic [7:0] a, e);
    op(0, a, 8'h00);
    chk(o_rdata, e);
  endtask
  task t_reset;
    rd(8'h02, 8'h07);
    rd(8'h03, 8'h05);
    rd(8'h04, 8'h00);
    rd(8'h00, 8'h00);
    chk(o_addr_valid, 0);
    chk(o_converter_enable, 0);
    chk({o_chg_det_sdp, o_chg_det_cdp, o_chg_det_reserved}, 3'h4);
    chk(o_usb_current_threshold_code, 3'h7);
    chk(o_bus_limit_undervoltage_fault_en, 1);
    chk({o_fault_retry_period, o_typec_detect_disable, o_advertised_source_current}, 5'h01);
    chk(o_comp_gain_code, 0);
    rd(8'h06, 8'h00);
    chk(o_addr_valid, 0);
    $display("reset done");
  endtask
  task t_gain;
    for (int c = 0; c < 32; c += 31) begin
      op(1, 8'h01, 8'hE0 | c);
      chk(o_comp_resistance_mohm, c * 18);
      chk(o_comp_gain_code, c);
    end
    rd(8'h01, 8'h1F);
    $display("gain done");
  endtask
  task t_fault;
    op(1, 8'h02, 8'hFF);
    chk(o_bus_limit_undervoltage_fault_en, 0);
    rd(8'h02, 8'h17);
    op(1, 8'h02, 8'h03);
    chk(o_bus_limit_undervoltage_fault_en, 1);
    chk(o_usb_current_threshold_code, 3'h3);
    $display("fault done");
  endtask
  task t_chg_det;
    for (int c = 0; c < 4; c++) begin
      op(1, 8'h03, c << 4 | 8'h04);
      chk({o_chg_det_sdp, o_chg_det_cdp, o_chg_det_reserved}, {c == 0, c == 1, c > 1});
    end
    op(1, 8'h03, 8'hCB);
    chk({o_fault_retry_period, o_typec_detect_disable, o_advertised_source_current}, 5'h1F);
    chk(o_chg_det_sdp, 1);
    op(1, 8'h03, 8'h04);
    chk({o_fault_retry_period, o_typec_detect_disable, o_advertised_source_current}, 5'h00);
    $display("charge detect done");
  endtask
  task t_config;
    chk(o_cable_power_passthru_enable, 0);
    op(1, 8'h04, 8'h01);
    chk({o_converter_enable, o_cable_power_passthru_enable}, 2'h3);
    op(1, 8'h03, 8'h00);
    chk(o_cable_power_passthru_enable, 0);
    $display("config done");
  endtask
  task t_sample;
    op(1, 8'h05, 8'h01);
    rd(8'h05, 8'h01);
    rd(8'h05, 8'h00);
    op(1, 8'h05, 8'h00);
    rd(8'h05, 8'h00);
    chk(o_addr_valid, 1);
    $display("sample done");
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    #1 i_nrst = 1;
    t_reset();
    t_gain();
    t_fault();
    t_chg_det();
    t_config();
    t_sample();
    final_report();
  end
  // watchdog well past the expected run
  initial begin
    #20000;
    bad_count++;
    final_report();
  end
endmodule
`default_nettype wire
